// ==== rtl/pfpb_pkg.sv ====
// Shared constants, types and decode helpers for the PCS FIFO, polarity and bit slip block.
// Assumes a single 100 MHz APB clock that also times both datapath sides.
package pfpb_pkg;

   // Datapath and FIFO geometry defaults.
   localparam int LANE_W = 64;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_PFULL = 6;
   localparam int FIFO_PEMPTY = 1;
   localparam int ENH_SLIP_W = 6;
   localparam int STD_SLIP_W = 5;

   // APB register byte offsets and address width.
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTRL_OFF = 12'h000;
   localparam logic [11:0] SLIP_OFF = 12'h004;
   localparam logic [11:0] STAT_OFF = 12'h008;

   // Control register fields and reset value.
   localparam int CTRL_W = 8;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Slip register fields and reset value.
   localparam int SLIP_ENH_LSB = 0;
   localparam int SLIP_STD_LSB = 8;
   localparam logic [31:0] SLIP_RST = 32'h0000_0000;
   // Status register field positions.
   localparam int STAT_OFFSET_LSB = 0;
   localparam int STAT_FLAG_LSB = 8;
   localparam int STAT_TXLVL_LSB = 16;
   localparam int STAT_RXLVL_LSB = 24;

   // Number of flip-flops that retime the asynchronous slip request.
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {FM_PHASE, FM_BASIC, FM_REGISTER, FM_CLKCOMP} pfpb_fifo_mode_type;
   typedef enum logic [1:0] {EC_CUSTOM, EC_10GR, EC_10GR_1588, EC_10GR_KRFEC} pfpb_eth_cfg_type;

   // Control register layout, most significant field first.
   typedef struct packed {
      logic gear_odd;
      logic rx_polinv;
      logic tx_polinv;
      logic pcs_std;
      logic [1:0] eth_cfg;
      logic [1:0] fifo_mode;
   } pfpb_ctrl_type;

   // FIFO flags as seen by the status register.
   typedef struct packed {
      logic rx_full;
      logic rx_pempty;
      logic tx_empty;
      logic tx_pfull;
   } pfpb_flags_type;

   // Effective FIFO mode: the Ethernet presets override the user mode.
   function automatic pfpb_fifo_mode_type pfpb_eff_mode(input logic [1:0] user, input logic [1:0] cfg,
                                                        input logic is_tx);
      pfpb_fifo_mode_type m;
      case (pfpb_eth_cfg_type'(cfg))
         EC_10GR: m = is_tx ? FM_PHASE : FM_CLKCOMP;
         EC_10GR_1588: m = FM_REGISTER;
         EC_10GR_KRFEC: m = is_tx ? FM_PHASE : FM_CLKCOMP;
         default: m = pfpb_fifo_mode_type'(user);
      endcase
      return m;
   endfunction

endpackage

// ==== rtl/pfpb_fifo.sv ====
// Small synchronous FIFO with registered read data and partial flags.
// Assumes writer and reader share pclk; the pop result appears one cycle later.
`timescale 1ns/1ps
`default_nettype none
module pfpb_fifo #(
   parameter int W = 64,
   parameter int DEPTH = 8,
   parameter int PFULL = 6,
   parameter int PEMPTY = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_valid,
   input wire logic [W-1:0] wr_data,
   input wire logic rd_pop,
   output logic [W-1:0] rd_data,
   output logic rd_valid,
   output logic [$clog2(DEPTH):0] level,
   output logic full,
   output logic empty,
   output logic pfull,
   output logic pempty
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW:0] PFULL_C = (AW+1)'(PFULL);
   localparam logic [AW:0] PEMPTY_C = (AW+1)'(PEMPTY);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0] wptr;
      logic [AW:0] rptr;
      logic [W-1:0] rdata;
      logic rvalid;
   } pfpb_fifo_state_type;

   pfpb_fifo_state_type s_q, s_d;

   // Occupancy flags come straight from the pointers so back-pressure is immediate.
   assign level = s_q.wptr - s_q.rptr;
   assign full = (level == DEPTH_C);
   assign empty = (level == '0);
   assign pfull = (level >= PFULL_C);
   assign pempty = (level <= PEMPTY_C);
   assign rd_data = s_q.rdata;
   assign rd_valid = s_q.rvalid;

   // A push into a full FIFO and a pop from an empty one are both dropped.
   always_comb begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      if (wr_valid && !full) begin
         s_d.mem[s_q.wptr[AW-1:0]] = wr_data;
         s_d.wptr = s_q.wptr + 1'b1;
      end
      if (rd_pop && !empty) begin
         s_d.rdata = s_q.mem[s_q.rptr[AW-1:0]];
         s_d.rptr = s_q.rptr + 1'b1;
         s_d.rvalid = 1'b1;
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule // pfpb_fifo
`default_nettype wire

// ==== rtl/pfpb_slip.sv ====
// Word-boundary shifter: delays the stream by a number of bit times across word borders.
// Assumes the amount stays below W; output is registered, one cycle behind the input.
`timescale 1ns/1ps
`default_nettype none
module pfpb_slip #(
   parameter int W = 64,
   parameter int AW = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   input wire logic [AW-1:0] amt,
   output logic [W-1:0] out_data,
   output logic out_valid
);
   typedef struct packed {
      logic [W-1:0] prev;
      logic [W-1:0] data;
      logic valid;
   } pfpb_slip_state_type;

   pfpb_slip_state_type s_q, s_d;
   logic [2*W-1:0] joined;
   logic [AW:0] shift;

   assign out_data = s_q.data;
   assign out_valid = s_q.valid;

   // Older bits from the previous word fill the low end, so a slip of n delays the stream by n UI.
   always_comb begin
      s_d = s_q;
      s_d.valid = in_valid;
      shift = (AW+1)'(W) - {1'b0, amt};
      joined = {in_data, s_q.prev} >> shift;
      if (in_valid) begin
         s_d.data = joined[W-1:0];
         s_d.prev = in_data;
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule // pfpb_slip
`default_nettype wire

// ==== rtl/pfpb_top.sv ====
// Per-channel PCS datapath: core FIFOs, polarity inversion and bit slip, with an APB control port.
// Assumes the fabric and PCS sides both run on pclk; only the RX slip request is asynchronous.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pfpb_top
   import pfpb_pkg::*;
#(
   parameter int W = LANE_W,
   parameter int DEPTH = FIFO_DEPTH,
   parameter int PFULL = FIFO_PFULL,
   parameter int PEMPTY = FIFO_PEMPTY
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic [W-1:0] tx_data,
   input wire logic tx_wr_en,
   output logic tx_fifo_pfull,
   output logic tx_fifo_full,
   input wire logic tx_pcs_ready,
   output logic [W-1:0] tx_pcs_data,
   output logic tx_pcs_valid,
   input wire logic [W-1:0] rx_pcs_data,
   input wire logic rx_pcs_valid,
   input wire logic rx_rd_en,
   output logic [W-1:0] rx_data,
   output logic rx_data_valid,
   output logic rx_fifo_pempty,
   output logic rx_fifo_empty,
   input wire logic rx_slip
);
   localparam int AW = $clog2(W);
   localparam int LW = $clog2(DEPTH) + 1;
   localparam logic [AW-1:0] SLIP_MAX = AW'(W - 1);

   typedef struct packed {
      pfpb_ctrl_type ctrl;
      logic [ENH_SLIP_W-1:0] tx_slip_enh;
      logic [STD_SLIP_W-1:0] tx_slip_std;
      logic [31:0] prdata;
      logic pslverr;
      logic [SYNC_STAGES-1:0] slip_sync;
      logic slip_seen;
      logic [AW-1:0] rx_offset;
      logic [W-1:0] tx_reg;
      logic tx_reg_vld;
      logic [W-1:0] rx_reg;
      logic rx_reg_vld;
      logic [W-1:0] rx_out;
      logic rx_out_vld;
      logic gear_phase;
   } pfpb_top_state_type;

   pfpb_top_state_type s_q, s_d;
   pfpb_fifo_mode_type tx_mode, rx_mode;
   pfpb_flags_type flags;
   logic [LW-1:0] tx_level, rx_level;
   logic tx_empty, rx_full;
   logic [W-1:0] txf_data, rxf_data, tx_word, rx_slipped;
   logic txf_vld, rxf_vld, tx_word_vld, rx_slipped_vld;
   logic tx_push, tx_pop, rx_push, rx_pop;
   logic [AW-1:0] tx_amt;
   logic slip_rise;
   logic [W-1:0] rx_word;
   logic setup_rd, access;

   // Effective modes follow the Ethernet preset before the user's own choice.
   assign tx_mode = pfpb_eff_mode(s_q.ctrl.fifo_mode, s_q.ctrl.eth_cfg, 1'b1);
   assign rx_mode = pfpb_eff_mode(s_q.ctrl.fifo_mode, s_q.ctrl.eth_cfg, 1'b0);

   // TX FIFO steering: register mode bypasses the FIFO for a fixed two-cycle latency to the PCS output.
   assign tx_push = tx_wr_en && (tx_mode != FM_REGISTER);
   assign tx_pop = tx_pcs_ready && (tx_mode != FM_REGISTER);
   assign tx_word = (tx_mode == FM_REGISTER) ? s_q.tx_reg : txf_data;
   assign tx_word_vld = (tx_mode == FM_REGISTER) ? s_q.tx_reg_vld : txf_vld;

   // Standard PCS takes the five-bit select, enhanced the six-bit value; both clip at width minus one.
   always_comb begin
      if (s_q.ctrl.pcs_std) begin
         tx_amt = AW'(s_q.tx_slip_std);
      end else begin
         tx_amt = AW'(s_q.tx_slip_enh);
      end
      if (tx_amt > SLIP_MAX) begin
         tx_amt = SLIP_MAX;
      end
   end

   pfpb_fifo #(.W(W), .DEPTH(DEPTH), .PFULL(PFULL), .PEMPTY(PEMPTY)) u_tx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .wr_valid(tx_push),
      .wr_data(tx_data),
      .rd_pop(tx_pop),
      .rd_data(txf_data),
      .rd_valid(txf_vld),
      .level(tx_level),
      .full(tx_fifo_full),
      .empty(tx_empty),
      .pfull(tx_fifo_pfull),
      .pempty()
   );

   // Inversion sits ahead of the static slip; the slip is a steady level, not a one-shot.
   pfpb_slip #(.W(W), .AW(AW)) u_tx_slip (
      .pclk(pclk),
      .presetn(presetn),
      .in_data(tx_word ^ {W{s_q.ctrl.tx_polinv}}),
      .in_valid(tx_word_vld),
      .amt(tx_amt),
      .out_data(tx_pcs_data),
      .out_valid(tx_pcs_valid)
   );

   // RX boundary shifter driven by the accumulated slip count.
   pfpb_slip #(.W(W), .AW(AW)) u_rx_slip (
      .pclk(pclk),
      .presetn(presetn),
      .in_data(rx_pcs_data),
      .in_valid(rx_pcs_valid),
      .amt(s_q.rx_offset),
      .out_data(rx_slipped),
      .out_valid(rx_slipped_vld)
   );

   assign rx_word = rx_slipped ^ {W{s_q.ctrl.rx_polinv}};
   assign rx_push = rx_slipped_vld && (rx_mode != FM_REGISTER);
   // Phase mode drains on its own so a fabric that ignores the flags still sees a steady stream.
   assign rx_pop = (rx_mode == FM_PHASE) ? 1'b1 : rx_rd_en;

   pfpb_fifo #(.W(W), .DEPTH(DEPTH), .PFULL(PFULL), .PEMPTY(PEMPTY)) u_rx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .wr_valid(rx_push),
      .wr_data(rx_word),
      .rd_pop(rx_pop && (rx_mode != FM_REGISTER)),
      .rd_data(rxf_data),
      .rd_valid(rxf_vld),
      .level(rx_level),
      .full(rx_full),
      .empty(rx_fifo_empty),
      .pfull(),
      .pempty(rx_fifo_pempty)
   );

   // The request is only looked at after the second flop; the held-high time covers its latency.
   assign slip_rise = s_q.slip_sync[SYNC_STAGES-1] && !s_q.slip_seen;

   assign flags = '{rx_full: rx_full, rx_pempty: rx_fifo_pempty, tx_empty: tx_empty, tx_pfull: tx_fifo_pfull};
   assign setup_rd = psel && !penable;
   assign access = psel && penable;

   assign pready = 1'b1;
   assign prdata = s_q.prdata;
   assign pslverr = s_q.pslverr;
   assign rx_data = s_q.rx_out;
   assign rx_data_valid = s_q.rx_out_vld;

   // Next-state logic for registers, synchroniser, slip count and output stages.
   always_comb begin
      s_d = s_q;
      // Read data and error are prepared during the setup cycle so that the zero-wait answer is a flop.
      if (setup_rd) begin
         s_d.prdata = '0;
         s_d.pslverr = 1'b0;
         case (paddr)
            CTRL_OFF: s_d.prdata = 32'(s_q.ctrl);
            SLIP_OFF: begin
               s_d.prdata[SLIP_ENH_LSB +: ENH_SLIP_W] = s_q.tx_slip_enh;
               s_d.prdata[SLIP_STD_LSB +: STD_SLIP_W] = s_q.tx_slip_std;
            end
            STAT_OFF: begin
               s_d.prdata[STAT_OFFSET_LSB +: AW] = s_q.rx_offset;
               s_d.prdata[STAT_FLAG_LSB +: 4] = flags;
               s_d.prdata[STAT_TXLVL_LSB +: LW] = tx_level;
               s_d.prdata[STAT_RXLVL_LSB +: LW] = rx_level;
            end
            default: s_d.pslverr = 1'b1;
         endcase
      end
      if (access && pwrite) begin
         case (paddr)
            CTRL_OFF: s_d.ctrl = pfpb_ctrl_type'(pwdata[CTRL_W-1:0]);
            SLIP_OFF: begin
               s_d.tx_slip_enh = pwdata[SLIP_ENH_LSB +: ENH_SLIP_W];
               s_d.tx_slip_std = pwdata[SLIP_STD_LSB +: STD_SLIP_W];
            end
            default: ;
         endcase
      end
      // Two-flop synchroniser followed by an edge memory.
      s_d.slip_sync = {s_q.slip_sync[SYNC_STAGES-2:0], rx_slip};
      s_d.slip_seen = s_q.slip_sync[SYNC_STAGES-1];
      if (slip_rise) begin
         s_d.rx_offset = (s_q.rx_offset == SLIP_MAX) ? '0 : s_q.rx_offset + 1'b1;
      end
      // Register-mode stages: one flop each way, no flow control.
      s_d.tx_reg_vld = tx_wr_en;
      if (tx_wr_en) begin
         s_d.tx_reg = tx_data;
      end
      s_d.rx_reg_vld = rx_slipped_vld;
      if (rx_slipped_vld) begin
         s_d.rx_reg = rx_word;
      end
      // Odd gear ratios mark the word of every other cycle invalid; even ratios pass valid straight on.
      s_d.gear_phase = s_q.ctrl.gear_odd ? !s_q.gear_phase : 1'b1;
      if (rx_mode == FM_REGISTER) begin
         s_d.rx_out_vld = s_q.rx_reg_vld && s_d.gear_phase;
         s_d.rx_out = s_q.rx_reg;
      end else begin
         s_d.rx_out_vld = rxf_vld && s_d.gear_phase;
         if (rxf_vld) begin
            s_d.rx_out = rxf_data;
         end
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.ctrl <= pfpb_ctrl_type'(CTRL_RST);
         s_q.tx_slip_enh <= SLIP_RST[SLIP_ENH_LSB +: ENH_SLIP_W];
         s_q.tx_slip_std <= SLIP_RST[SLIP_STD_LSB +: STD_SLIP_W];
      end else begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Preset configurations pin the effective modes.
   property p_cfg_10gr;
      (s_q.ctrl.eth_cfg == EC_10GR) |-> (tx_mode == FM_PHASE) && (rx_mode == FM_CLKCOMP);
   endproperty
   a_cfg_10gr: assert property (p_cfg_10gr) else $error("10GBASE-R preset modes wrong");

   property p_cfg_1588;
      (s_q.ctrl.eth_cfg == EC_10GR_1588) |-> (tx_mode == FM_REGISTER) && (rx_mode == FM_REGISTER);
   endproperty
   a_cfg_1588: assert property (p_cfg_1588) else $error("timestamp preset not in register mode");

   property p_cfg_krfec;
      (s_q.ctrl.eth_cfg == EC_10GR_KRFEC) |-> (tx_mode == FM_PHASE) && (rx_mode == FM_CLKCOMP);
   endproperty
   a_cfg_krfec: assert property (p_cfg_krfec) else $error("KR FEC preset modes wrong");

   // Register mode: a written word reaches the PCS output exactly two cycles later.
   property p_reg_latency;
      (tx_mode == FM_REGISTER) && tx_wr_en ##1 (tx_mode == FM_REGISTER) |=> tx_pcs_valid;
   endproperty
   a_reg_latency: assert property (p_reg_latency) else $error("register mode latency broken");

   // With no slip, the TX output is the inverted word when the inversion bit was set.
   property p_tx_polinv;
      (tx_amt == '0) && tx_word_vld |=>
         tx_pcs_data == ($past(s_q.ctrl.tx_polinv) ? ~$past(tx_word) : $past(tx_word));
   endproperty
   a_tx_polinv: assert property (p_tx_polinv) else $error("TX polarity wrong");

   property p_rx_polinv;
      (s_q.rx_offset == '0) && rx_pcs_valid && (rx_mode == FM_REGISTER) && s_q.ctrl.rx_polinv
         ##1 s_q.ctrl.rx_polinv |=> s_q.rx_reg == ~$past(rx_pcs_data, 2);
   endproperty
   a_rx_polinv: assert property (p_rx_polinv) else $error("RX polarity wrong");

   // The enhanced value must reach the shifter unchanged, and never beyond width minus one.
   property p_slip_max;
      (tx_amt <= SLIP_MAX) && (s_q.ctrl.pcs_std || (tx_amt == AW'(s_q.tx_slip_enh)));
   endproperty
   a_slip_max: assert property (p_slip_max) else $error("TX slip beyond width minus one");

   property p_std_sel;
      s_q.ctrl.pcs_std && (32'(s_q.tx_slip_std) < W) |-> tx_amt == AW'(s_q.tx_slip_std);
   endproperty
   a_std_sel: assert property (p_std_sel) else $error("standard slip select ignored");

   // A held request moves the boundary once, then holds it.
   property p_one_slip;
      $rose(s_q.slip_sync[SYNC_STAGES-1]) |=>
         (s_q.rx_offset == (($past(s_q.rx_offset) == SLIP_MAX) ? '0 : $past(s_q.rx_offset) + 1'b1))
         ##1 ($stable(s_q.rx_offset) || !s_q.slip_sync[SYNC_STAGES-1]);
   endproperty
   a_one_slip: assert property (p_one_slip) else $error("slip request not exactly one bit");

   property p_no_spurious_slip;
      !slip_rise |=> $stable(s_q.rx_offset);
   endproperty
   a_no_spurious_slip: assert property (p_no_spurious_slip) else $error("boundary moved without edge");

   // Odd gear never shows valid on two cycles in a row.
   property p_gear_odd;
      s_q.ctrl.gear_odd && rx_data_valid ##1 s_q.ctrl.gear_odd |-> !rx_data_valid;
   endproperty
   a_gear_odd: assert property (p_gear_odd) else $error("odd gear valid did not toggle");
endmodule // pfpb_top
`default_nettype wire

// ==== verification/pfpb_fabric_model.sv ====
// Fabric core logic model: derives the TX write enable and the RX read enable from the FIFO flags.
// Assumes one clock shared with the block; the bench supplies the data words and transfer requests.
`timescale 1ns/1ps
`default_nettype none
module pfpb_fabric_model (
   input wire logic basic,
   input wire logic tx_req,
   input wire logic stall,
   input wire logic tx_fifo_pfull,
   input wire logic rx_fifo_pempty,
   output logic tx_wr_en,
   output logic rx_rd_en
);
   // Basic mode throttles on the partial flags; the other modes may simply hold the enable high.
   assign tx_wr_en = basic ? (tx_req & ~tx_fifo_pfull) : tx_req;
   // A stalled reader lets the RX FIFO fill up, the way slow core logic would.
   assign rx_rd_en = basic ? (~rx_fifo_pempty & ~stall) : ~stall;
endmodule // pfpb_fabric_model
`default_nettype wire

// ==== verification/pfpb_top_tb.sv ====
// Self-checking bench for the FIFO, polarity and bit slip block, driven through APB and both streams.
// Assumes the fabric model beside the block and a single 100 MHz clock for every side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module pfpb_top_tb;
   import pfpb_pkg::*;
   localparam int W = LANE_W;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, perr, tx_wr_en, tx_fifo_pfull, tx_fifo_full, tx_pcs_valid, rx_rd_en;
   logic rx_data_valid, rx_fifo_pempty, rx_fifo_empty;
   logic tx_pcs_ready = 1'b1, rx_pcs_valid = 1'b0, rx_slip = 1'b0, basic = 1'b0, tx_req = 1'b0, stall = 1'b0;
   logic [W-1:0] tx_data = '0, rx_pcs_data = '0, tx_pcs_data, rx_data;
   logic [W-1:0] txq[$], rxq[$];
   logic [W-1:0] w[4] = '{64'h0123456789abcdef, 64'hfedcba9876543210, 64'hc3a55a3c0ff0f00f, 64'h8000000000000001};
   logic [31:0] tc[5] = '{32'h00, 32'h20, 32'h00, 32'h10, 32'h30};
   logic [31:0] ts[5] = '{32'h0, 32'h1, 32'h3f, 32'h300, 32'h1f00};
   int tn[5] = '{0, 1, 63, 3, 31};
   int num_errors = 0, total_checks = 0;

   pfpb_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .tx_data, .tx_wr_en, .tx_fifo_pfull, .tx_fifo_full, .tx_pcs_ready, .tx_pcs_data, .tx_pcs_valid,
      .rx_pcs_data, .rx_pcs_valid, .rx_rd_en, .rx_data, .rx_data_valid, .rx_fifo_pempty, .rx_fifo_empty, .rx_slip);
   pfpb_fabric_model fab_u (.basic, .tx_req, .stall, .tx_fifo_pfull, .rx_fifo_pempty, .tx_wr_en, .rx_rd_en);

   // Core and PCS sides share this clock, which keeps the core clock inside the allowed band.
   always #5 pclk = ~pclk;

   // Collect every word the block marks valid; words shown with valid low are discarded.
   always @(posedge pclk) begin
      if (tx_pcs_valid === 1'b1) txq.push_back(tx_pcs_data);
      if (rx_data_valid === 1'b1) rxq.push_back(rx_data);
   end

   // Expected stream after a slip of n bit times, the previous word filling the vacated bits.
   function automatic logic [W-1:0] slp(input logic [W-1:0] c, input logic [W-1:0] p, input int n);
      logic [2*W-1:0] x;
      x = {c, p} >> (W - n);
      return x[W-1:0];
   endfunction

   // One APB transfer; it starts one edge late so that the previous release never collides with it.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cfg(input logic [31:0] c, input logic [31:0] s);
      apb(1'b1, CTRL_OFF, c);
      apb(1'b1, SLIP_OFF, s);
   endtask

   // Four words back to back on the TX fabric side or the RX PCS side.
   task automatic send(input bit rx);
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         if (rx) begin
            rx_pcs_valid <= 1'b1;
            rx_pcs_data <= w[i];
         end else begin
            tx_req <= 1'b1;
            tx_data <= w[i];
         end
      end
      @(posedge pclk);
      rx_pcs_valid <= 1'b0;
      tx_req <= 1'b0;
   endtask

   // Bounded wait for a number of collected words.
   task automatic wq(input bit rx, input int n);
      int k;
      k = 0;
      while ((rx ? rxq.size() : txq.size()) < n && k < 30) begin
         @(posedge pclk);
         k++;
      end
      if ((rx ? rxq.size() : txq.size()) < n) begin
         num_errors++;
         $display("[FAIL] words collected exp %0d got %0d", n, (rx ? rxq.size() : txq.size()));
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // A hang is cut short far beyond the few hundred cycles the tests need.
   initial begin
      #100000;
      num_errors++;
      print_verdict();
   end

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CTRL_OFF, 32'h0);
      `CHK("ctrl reset", 32'h0, rd)
      apb(1'b0, SLIP_OFF, 32'h0);
      `CHK("slip reset", SLIP_RST, rd)
      apb(1'b0, 12'h00c, 32'h0);
      `CHK("unmapped err", 1'b1, perr)
      `CHK("rx empty reset", 1'b1, rx_fifo_empty)
      $display("test reset done");
      // Slip amounts at both ends of the range, with and without inversion, in both PCS kinds.
      for (int i = 0; i < 5; i++) begin
         cfg(tc[i], ts[i]);
         txq.delete();
         send(1'b0);
         wq(1'b0, 4);
         for (int j = 1; j < 4; j++) begin
            `CHK("tx word", slp(w[j] ^ {W{tc[i][5]}}, w[j-1] ^ {W{tc[i][5]}}, tn[i]), txq[j])
         end
      end
      $display("test tx done");
      // Each held request must give exactly one bit of slip.
      for (int i = 0; i < 2; i++) begin
         @(posedge pclk);
         rx_slip <= 1'b1;
         repeat (3) @(posedge pclk);
         rx_slip <= 1'b0;
         repeat (3) @(posedge pclk);
      end
      apb(1'b0, STAT_OFF, 32'h0);
      `CHK("slip offset", 6'h02, rd[5:0])
      cfg(32'h42, 32'h0);
      rxq.delete();
      send(1'b1);
      wq(1'b1, 4);
      `CHK("rx even count", 4, rxq.size())
      for (int j = 1; j < 4; j++) begin
         `CHK("rx word", slp(~w[j], ~w[j-1], 2), rxq[j])
      end
      cfg(32'hc2, 32'h0);
      rxq.delete();
      send(1'b1);
      wq(1'b1, 2);
      repeat (8) @(posedge pclk);
      `CHK("rx odd count", 2, rxq.size())
      $display("test rx done");
      // Timestamping preset forces register mode, so words pass although the PCS side is not popping.
      cfg(32'h09, 32'h0);
      tx_pcs_ready <= 1'b0;
      txq.delete();
      send(1'b0);
      wq(1'b0, 4);
      `CHK("1588 tx count", 4, txq.size())
      cfg(32'h01, 32'h0);
      basic <= 1'b1;
      tx_req <= 1'b1;
      repeat (12) @(posedge pclk);
      `CHK("tx pfull", 1'b1, tx_fifo_pfull)
      `CHK("tx full", 1'b0, tx_fifo_full)
      apb(1'b0, STAT_OFF, 32'h0);
      `CHK("tx level", 4'h6, rd[19:16])
      tx_req <= 1'b0;
      tx_pcs_ready <= 1'b1;
      txq.delete();
      wq(1'b0, 6);
      apb(1'b0, STAT_OFF, 32'h0);
      `CHK("tx drained", 1'b1, rd[9])
      $display("test tx basic done");
      // A stalled reader first lets four words collect in the RX FIFO, then drains it down to the partial-empty mark.
      stall <= 1'b1;
      rxq.delete();
      send(1'b1);
      repeat (3) @(posedge pclk);
      apb(1'b0, STAT_OFF, 32'h0);
      `CHK("rx level full", 4'h4, rd[27:24])
      stall <= 1'b0;
      wq(1'b1, 3);
      apb(1'b0, STAT_OFF, 32'h0);
      `CHK("rx level low", 4'h1, rd[27:24])
      `CHK("rx pempty", 1'b1, rx_fifo_pempty)
      $display("test rx basic done");
      // Ethernet presets: TX runs as a phase FIFO, RX waits on the stalled reader and keeps its word.
      stall <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         cfg(i ? 32'h0c : 32'h04, 32'h0);
         txq.delete();
         send(1'b0);
         wq(1'b0, 4);
         `CHK("preset tx count", 4, txq.size())
         apb(1'b0, STAT_OFF, 32'h0);
         `CHK("preset rx level", 4'h1, rd[27:24])
      end
      $display("test presets done");
      // A reset in mid-run clears the slip offset, so inversion alone shows in register mode.
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, STAT_OFF, 32'h0);
      `CHK("offset after reset", 6'h00, rd[5:0])
      cfg(32'h42, 32'h0);
      rxq.delete();
      send(1'b1);
      wq(1'b1, 4);
      for (int j = 0; j < 4; j++) begin
         `CHK("rx inverted", ~w[j], rxq[j])
      end
      $display("test mid reset done");
      print_verdict();
   end
endmodule // pfpb_top_tb
`default_nettype wire
